// file: jump_arith_regs.vh
// constants for the jump and arithmetic datapath
`ifndef JUMP_ARITH_REGS_VH
`define JUMP_ARITH_REGS_VH
// ==========================================
// operation codes
`define OP_ADD_CARRY_ONLY  4'h0
`define OP_SUM_OPERANDS    4'h1
`define OP_SUM_WITH_CARRY  4'h2
`define OP_MASK_INTERSECT  4'h3
`define OP_TEST_MASK       4'h4
`define OP_CLEAR_MASKED    4'h5
`define OP_SET_MASKED      4'h6
`define OP_JUMP            4'h7
// ==========================================
// jump condition field encodings
`define COND_NONZERO       3'h0
`define COND_ZERO          3'h1
`define COND_NO_CARRY      3'h2
`define COND_CARRY         3'h3
`define COND_NEGATIVE      3'h4
`define COND_SIGNED_GE     3'h5
`define COND_SIGNED_LT     3'h6
`define COND_ALWAYS        3'h7
// ==========================================
// status register bit positions
`define SR_CARRY_BIT       0
`define SR_ZERO_BIT        1
`define SR_NEG_BIT         2
`define SR_GIE_BIT         3
`define SR_HALT_BIT        4
`define SR_OSCILLATOR_OFF_BIT_BIT      5
`define SR_OVF_BIT         8
// ==========================================
// reset values and jump arithmetic
`define STATUS_RESET       16'h0000
`define RESULT_RESET       16'h0000
`define PC_RESET           16'h0000
`define PC_STEP            16'h0002
`define JUMP_OFFSET_BITS   10
`endif

// file: jump_cond_eval.v
// jump condition evaluation from the status flags
`timescale 1ns/1ns
`default_nettype none
`include "jump_arith_regs.vh"
module jump_cond_eval (
    // condition field
    input  wire [2:0] cond,
    // current flags
    input  wire       flagN,
    input  wire       flagZ,
    input  wire       flagC,
    input  wire       flagV,
    // decision
    output reg        taken
);
    // ==========================================
    // fixed condition mapping
    always @* begin // [RULE_19]
        case (cond)
            `COND_ZERO:      taken = flagZ;            // [RULE_02]
            `COND_NONZERO:   taken = ~flagZ;           // [RULE_02]
            `COND_CARRY:     taken = flagC;            // [RULE_02]
            `COND_NO_CARRY:  taken = ~flagC;           // [RULE_02]
            `COND_NEGATIVE:  taken = flagN;            // [RULE_02]
            `COND_SIGNED_GE: taken = ~(flagN ^ flagV); // [RULE_03]
            `COND_SIGNED_LT: taken = flagN ^ flagV;    // [RULE_03]
            default:         taken = 1'b1;             // [RULE_04]
        endcase
    end
endmodule // jump_cond_eval
`default_nettype wire

// file: byte_word_adder.v
// adder with byte/word carry and overflow extraction
`timescale 1ns/1ns
`default_nettype none
module byte_word_adder (
    // operands
    input  wire [15:0] opA,
    input  wire [15:0] opB,
    input  wire        carryIn,
    input  wire        byteMode,
    // results
    output wire [15:0] sum,
    output wire        carryOut,
    output wire        overflow
);
    wire [16:0] wordSum;
    wire [8:0]  byteSum;
    // ==========================================
    // both widths, selected by mode
    assign wordSum  = {1'b0, opA} + {1'b0, opB} + {16'h0000, carryIn};
    assign byteSum  = {1'b0, opA[7:0]} + {1'b0, opB[7:0]}
                    + {8'h00, carryIn};
    assign sum      = byteMode ? {8'h00, byteSum[7:0]} : wordSum[15:0]; // [RULE_18]
    assign carryOut = byteMode ? byteSum[8] : wordSum[16];
    assign overflow = byteMode
        ? (opA[7] == opB[7]) && (byteSum[7] != opA[7])
        : (opA[15] == opB[15]) && (wordSum[15] != opA[15]); // [RULE_10]
endmodule // byte_word_adder
`default_nettype wire

// file: jump_arith_logic.v
// jump target and add/logic execution datapath
// How it works
// RULE_01 - target is old pc plus 2 plus 2*offset
// RULE_02 - zero, nonzero, carry, nocarry, negative jump tests
// RULE_03 - signed ge/lt jump on N xor V
// RULE_04 - unconditional jump always taken
// RULE_05 - jumps never change status flags
// RULE_06 - add carry only, carry on wrap
// RULE_07 - add source to destination, carry out
// RULE_08 - add with incoming carry, carry out
// RULE_09 - adds set N and Z from result
// RULE_10 - adds set V on signed overflow
// RULE_11 - and writes source and destination
// RULE_12 - and forms: N=msb, Z, C=!Z, V=0
// RULE_13 - test form updates flags, writes nothing
// RULE_14 - clear masked bits, flags unchanged
// RULE_15 - set masked bits, flags unchanged
// RULE_16 - mode bits never altered here
// RULE_17 - byte select 0 word, 1 byte
// RULE_18 - byte form uses low eight bits
// RULE_19 - one fixed condition field mapping
`timescale 1ns/1ns
`default_nettype none
`include "jump_arith_regs.vh"
module jump_arith_logic (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // decoded instruction
    input  wire        opValid,
    input  wire [3:0]  opCode,
    input  wire        byteSel,
    input  wire [2:0]  jumpCond,
    input  wire [9:0]  jumpOffset,
    // operands and state
    input  wire [15:0] srcVal,
    input  wire [15:0] dstVal,
    input  wire [15:0] statusIn,
    input  wire [15:0] pcIn,
    // results
    output reg  [15:0] result_q,
    output reg         resultWrite_q,
    output reg  [15:0] statusOut_q,
    output reg  [15:0] pcNext_q,
    output reg         jumpTaken_q,
    output reg         done_q
);
    wire        inN = statusIn[`SR_NEG_BIT];
    wire        inZ = statusIn[`SR_ZERO_BIT];
    wire        inC = statusIn[`SR_CARRY_BIT];
    wire        inV = statusIn[`SR_OVF_BIT];
    wire        taken;
    wire        jumpGo;
    wire [15:0] addSum;
    wire        addCarry;
    wire        addOvf;

    // datapath combinational values
    reg  [15:0] addB;
    reg         addCin;
    reg  [15:0] result_d;
    reg         resultWrite_d;
    reg  [15:0] status_d;
    reg  [15:0] pc_d;

    // next flag values
    reg         nextN;
    reg         nextZ;
    reg         nextC;
    reg         nextV;

    // operation decode
    wire        isAddCarry;
    wire        isSum;
    wire        isSumCarry;
    wire        isAnd;
    wire        isTest;
    wire        isClear;
    wire        isSet;
    wire        isJump;
    wire        isAddForm;
    wire        isAndForm;
    wire        isBitForm;

    // operand views
    wire [15:0] byteMask;
    wire [15:0] srcM;
    wire [15:0] dstM;
    wire [15:0] offExt;

    // add family
    wire        addMsb;
    wire        addZeroByte;
    wire        addZeroWord;
    wire        addZero;

    // logic family
    wire [15:0] andRes;
    wire [15:0] clrRes;
    wire [15:0] setRes;
    wire        andMsb;
    wire        andZeroByte;
    wire        andZeroWord;
    wire        andZero;

    // jump target
    wire [15:0] pcSeq;
    wire [15:0] pcJump;

    // ==========================================
    // operation decode
    assign isAddCarry = (opCode == `OP_ADD_CARRY_ONLY);
    assign isSum      = (opCode == `OP_SUM_OPERANDS);
    assign isSumCarry = (opCode == `OP_SUM_WITH_CARRY);
    assign isAnd      = (opCode == `OP_MASK_INTERSECT);
    assign isTest     = (opCode == `OP_TEST_MASK);
    assign isClear    = (opCode == `OP_CLEAR_MASKED);
    assign isSet      = (opCode == `OP_SET_MASKED);
    assign isJump     = (opCode == `OP_JUMP);

    // operation families
    assign isAddForm  = isAddCarry | isSum | isSumCarry;
    assign isAndForm  = isAnd | isTest;
    assign isBitForm  = isClear | isSet;

    // ==========================================
    // operand views
    assign byteMask = byteSel ? 16'h00ff : 16'hffff; // [RULE_17]
    assign srcM     = srcVal & byteMask; // [RULE_18]
    assign dstM     = dstVal & byteMask; // [RULE_18]
    assign offExt   = {{5{jumpOffset[`JUMP_OFFSET_BITS-1]}},
                       jumpOffset, 1'b0}; // [RULE_01]

    // ==========================================
    // condition and adder
    jump_cond_eval condUnit (
        .cond  (jumpCond),
        .flagN (inN),
        .flagZ (inZ),
        .flagC (inC),
        .flagV (inV),
        .taken (taken)
    );
    assign jumpGo = isJump & taken;

    always @* begin
        addB   = srcM;
        addCin = 1'b0;
        case (opCode)
            `OP_ADD_CARRY_ONLY: begin
                addB   = 16'h0000;
                addCin = inC; // [RULE_06]
            end
            `OP_SUM_WITH_CARRY: addCin = inC; // [RULE_08]
            default:            addCin = 1'b0; // [RULE_07]
        endcase
    end

    byte_word_adder adder (
        .opA      (dstM),
        .opB      (addB),
        .carryIn  (addCin),
        .byteMode (byteSel),
        .sum      (addSum),
        .carryOut (addCarry),
        .overflow (addOvf)
    );

    // ==========================================
    // add family flags
    assign addMsb      = byteSel ? addSum[7] : addSum[15]; // [RULE_18]
    assign addZeroByte = (addSum[7:0] == 8'h00);
    assign addZeroWord = (addSum == 16'h0000);
    assign addZero     = byteSel ? addZeroByte : addZeroWord; // [RULE_09]

    // ==========================================
    // logic family values and flags
    assign andRes      = srcM & dstM; // [RULE_11]
    assign clrRes      = ~srcM & dstM; // [RULE_14]
    assign setRes      = srcM | dstM; // [RULE_15]
    assign andMsb      = byteSel ? andRes[7] : andRes[15]; // [RULE_18]
    assign andZeroByte = (andRes[7:0] == 8'h00);
    assign andZeroWord = (andRes == 16'h0000);
    assign andZero     = byteSel ? andZeroByte : andZeroWord; // [RULE_12]

    // ==========================================
    // jump target
    assign pcSeq  = pcIn + `PC_STEP;
    assign pcJump = pcSeq + offExt; // [RULE_01]

    // ==========================================
    // destination value
    always @* begin
        result_d      = dstVal;
        resultWrite_d = 1'b0;
        if (isAddForm) begin
            result_d      = addSum; // [RULE_06] [RULE_07] [RULE_08]
            resultWrite_d = 1'b1;
        end else if (isAnd) begin
            result_d      = andRes; // [RULE_11]
            resultWrite_d = 1'b1;
        end else if (isTest) begin
            result_d      = andRes;
            resultWrite_d = 1'b0; // [RULE_13]
        end else if (isClear) begin
            result_d      = clrRes; // [RULE_14]
            resultWrite_d = 1'b1;
        end else if (isSet) begin
            result_d      = setRes; // [RULE_15]
            resultWrite_d = isBitForm;
        end
    end

    // ==========================================
    // negative flag
    always @* begin
        nextN = inN; // [RULE_05] [RULE_14] [RULE_15]
        if (isAddForm) begin
            nextN = addMsb; // [RULE_09]
        end else if (isAndForm) begin
            nextN = andMsb; // [RULE_12]
        end
    end

    // ==========================================
    // zero flag
    always @* begin
        nextZ = inZ; // [RULE_05]
        if (isAddForm) begin
            nextZ = addZero; // [RULE_09]
        end else if (isAndForm) begin
            nextZ = andZero; // [RULE_12]
        end
    end

    // ==========================================
    // carry flag
    always @* begin
        nextC = inC; // [RULE_05]
        if (isAddForm) begin
            nextC = addCarry; // [RULE_06] [RULE_07] [RULE_08]
        end else if (isAndForm) begin
            nextC = ~andZero; // [RULE_12]
        end
    end

    // ==========================================
    // overflow flag
    always @* begin
        nextV = inV; // [RULE_05]
        if (isAddForm) begin
            nextV = addOvf; // [RULE_10]
        end else if (isAndForm) begin
            nextV = 1'b0; // [RULE_12]
        end
    end

    // ==========================================
    // next status, mode bits copied through
    always @* begin
        status_d = statusIn; // [RULE_16]
        status_d[`SR_NEG_BIT]   = nextN;
        status_d[`SR_ZERO_BIT]  = nextZ;
        status_d[`SR_CARRY_BIT] = nextC;
        status_d[`SR_OVF_BIT]   = nextV;
    end

    // ==========================================
    // next program counter
    always @* begin
        pc_d = pcSeq;
        if (jumpGo) begin
            pc_d = pcJump; // [RULE_01]
        end
    end

    // ==========================================
    // output registers
    // one-cycle pulses
    always @(posedge core_clk) begin
        if (rst) begin
            resultWrite_q <= 1'b0;
            jumpTaken_q   <= 1'b0;
            done_q        <= 1'b0;
        end else begin
            done_q        <= opValid;
            resultWrite_q <= opValid & resultWrite_d;
            jumpTaken_q   <= opValid & jumpGo;
        end
    end

    // values held until the next operation
    always @(posedge core_clk) begin
        if (rst) begin
            result_q    <= `RESULT_RESET;
            statusOut_q <= `STATUS_RESET;
            pcNext_q    <= `PC_RESET;
        end else if (opValid) begin
            result_q    <= result_d;
            statusOut_q <= status_d; // [RULE_05]
            pcNext_q    <= pc_d;
        end
    end
endmodule // jump_arith_logic
`default_nettype wire

// file: jump_arith_asserts.sv
// assertions on the jump and arithmetic datapath ports
`timescale 1ns/1ns
`default_nettype none
module jump_arith_asserts (
    // clock, reset and request
    input wire logic        core_clk, rst, opValid, byteSel,
    input wire logic [3:0]  opCode,
    input wire logic [2:0]  jumpCond,
    input wire logic [9:0]  jumpOffset,
    input wire logic [15:0] srcVal, dstVal, statusIn, pcIn,
    // results
    input wire logic [15:0] result_q, statusOut_q, pcNext_q,
    input wire logic        resultWrite_q, jumpTaken_q, done_q
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
// ==========================================
// request sequences
sequence s_op(logic [3:0] c);
    opValid && opCode == c;
endsequence
sequence s_jmp;
    s_op(4'h7);
endsequence
// ==========================================
// properties
property p_target;
    s_jmp |=> pcNext_q == $past(pcIn) + 16'h2 + (jumpTaken_q ?
        {{5{$past(jumpOffset[9])}}, $past(jumpOffset), 1'b0} : 16'h0);
endproperty
a_target: assert property (p_target) else $error("bad target");
property p_zero;
    s_jmp ##0 jumpCond[2:1] == 2'h0 |=>
        jumpTaken_q == ($past(statusIn[1]) == $past(jumpCond[0]));
endproperty
a_zero: assert property (p_zero) else $error("bad zero jump");
property p_lt;
    s_jmp ##0 jumpCond == 3'h6 |=>
        jumpTaken_q == ($past(statusIn[2]) ^ $past(statusIn[8]));
endproperty
a_lt: assert property (p_lt) else $error("bad lt jump");
property p_always;
    s_jmp ##0 jumpCond == 3'h7 |=> jumpTaken_q;
endproperty
a_always: assert property (p_always) else $error("bad always");
property p_jflags;
    s_jmp |=> statusOut_q == $past(statusIn);
endproperty
a_jflags: assert property (p_jflags) else $error("jump flags");
property p_sum;
    s_op(4'h1) ##0 !byteSel |=>
        {statusOut_q[0], result_q} == $past(srcVal) + $past(dstVal);
endproperty
a_sum: assert property (p_sum) else $error("bad sum");
property p_andf;
    opValid && (opCode == 4'h3 || opCode == 4'h4) |=>
        statusOut_q[0] == !statusOut_q[1] && !statusOut_q[8];
endproperty
a_andf: assert property (p_andf) else $error("bad and flags");
property p_test;
    s_op(4'h4) |=> !resultWrite_q && done_q;
endproperty
a_test: assert property (p_test) else $error("test wrote");
property p_bits;
    opValid && (opCode == 4'h5 || opCode == 4'h6) |=>
        statusOut_q == $past(statusIn) && resultWrite_q;
endproperty
a_bits: assert property (p_bits) else $error("bits flags");
property p_mode;
    opValid |=> statusOut_q[5:3] == $past(statusIn[5:3]);
endproperty
a_mode: assert property (p_mode) else $error("mode bits");
endmodule // jump_arith_asserts
bind jump_arith_logic jump_arith_asserts i_jump_arith_asserts (.core_clk,
    .rst, .opValid, .byteSel, .opCode, .jumpCond, .jumpOffset, .srcVal,
    .dstVal, .statusIn, .pcIn, .result_q, .statusOut_q, .pcNext_q,
    .resultWrite_q, .jumpTaken_q, .done_q);
`default_nettype wire

// file: tb_jump_arith_logic.sv
// self-checking bench for the jump and arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
`include "jump_arith_regs.vh"
module tb_jump_arith_logic;
typedef struct packed {
    logic [3:0] op; logic b; logic [2:0] c; logic [9:0] off;
    logic [15:0] s, d, st, r; logic w; logic [15:0] so; logic t;
} row_t;
logic core_clk = 0, rst = 1, opValid = 0, byteSel = 0;
logic [3:0] opCode = 0;
logic [2:0] jumpCond = 0;
logic [9:0] jumpOffset = 0, off;
logic [15:0] srcVal = 0, dstVal = 0, statusIn = 0, pcIn = 16'h1000, ep, st;
wire [15:0] result_q, statusOut_q, pcNext_q;
wire resultWrite_q, jumpTaken_q, done_q;
integer fail_count = 0, comparisons = 0, k;
logic n, z, cy, v, et;
row_t rows[9];
jump_arith_logic i_jump_arith_logic (.core_clk, .rst, .opValid, .opCode,
    .byteSel, .jumpCond, .jumpOffset, .srcVal, .dstVal, .statusIn, .pcIn,
    .result_q, .resultWrite_q, .statusOut_q, .pcNext_q, .jumpTaken_q,
    .done_q);
// ==========================================
// helpers
task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
        fail_count++;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
endtask
task issue(input row_t x);
    @(posedge core_clk);
    opValid <= 1'b1;
    {opCode, byteSel, jumpCond, jumpOffset, srcVal, dstVal, statusIn} <=
        {x.op, x.b, x.c, x.off, x.s, x.d, x.st};
    @(posedge core_clk);
    opValid <= 1'b0;
    #1;
    chk({15'h0, done_q}, 16'h1);
endtask
task stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
// ==========================================
// clock, watchdog and sequence
initial forever #50 core_clk = ~core_clk;
initial begin
    #5000000;
    fail_count++;
    stop_test;
end
initial begin
    rows[0] = '{4'h1,1'h0,3'h0,10'h0,16'h1,16'hffff,16'h0,16'h0,1'h1,16'h3,1'h0};
    rows[1] = '{4'h1,1'h0,3'h0,10'h0,16'h7fff,16'h1,16'h0,16'h8000,1'h1,16'h104,1'h0};
    rows[2] = '{4'h1,1'h1,3'h0,10'h0,16'h80,16'h1280,16'h0,16'h0,1'h1,16'h103,1'h0};
    rows[3] = '{4'h2,1'h0,3'h0,10'h0,16'h1,16'h1,16'h1,16'h3,1'h1,16'h0,1'h0};
    rows[4] = '{4'h0,1'h1,3'h0,10'h0,16'h5,16'hff,16'h39,16'h0,1'h1,16'h3b,1'h0};
    rows[5] = '{4'h3,1'h0,3'h0,10'h0,16'hf0f0,16'h8f00,16'h100,16'h8000,1'h1,16'h5,1'h0};
    rows[6] = '{4'h4,1'h0,3'h0,10'h0,16'hff,16'hff00,16'h105,16'h0,1'h0,16'h2,1'h0};
    rows[7] = '{4'h5,1'h0,3'h0,10'h0,16'hff00,16'h1234,16'h107,16'h34,1'h1,16'h107,1'h0};
    rows[8] = '{4'h6,1'h1,3'h0,10'h0,16'hf0,16'h120f,16'h4,16'hff,1'h1,16'h4,1'h0};
    repeat (5) @(posedge core_clk);
    #1;
    chk(statusOut_q | pcNext_q | result_q, 16'h0);
    rst <= 1'b0;
    for (k = 0; k < 9; k++) begin
        issue(rows[k]);
        chk({15'h0, resultWrite_q}, {15'h0, rows[k].w});
        if (rows[k].w) chk(result_q, rows[k].r);
        chk(statusOut_q, rows[k].so);
        chk(pcNext_q, 16'h1002);
    end
    for (k = 0; k < 128; k++) begin
        {v, n, z, cy} = k[3:0];
        st = {7'h0, v, 5'h0, n, z, cy};
        off = k[0] ? 10'h200 : 10'h1ff;
        case (k[6:4])
            0: et = !z;
            1: et = z;
            2: et = !cy;
            3: et = cy;
            4: et = n;
            5: et = !(n ^ v);
            6: et = n ^ v;
            default: et = 1'b1;
        endcase
        ep = 16'h1002 + (et ? {{5{off[9]}}, off, 1'b0} : 16'h0);
        issue('{4'h7,1'h0,k[6:4],off,16'h0,16'h0,st,16'h0,1'h0,16'h0,1'h0});
        chk({15'h0, jumpTaken_q}, {15'h0, et});
        chk(statusOut_q, st);
        chk(pcNext_q, ep);
    end
    issue(rows[1]);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(statusOut_q | result_q, 16'h0);
    stop_test;
end
endmodule // tb_jump_arith_logic
`default_nettype wire
